//--- rtl/soi_pkg.sv
// Constants and carrier types for the safety output interlock logic.
// Assumes a single 20 MHz system clock and synchronous active-low reset.
// Behaviour
// R1 - Clear field, no holds: both outputs on
// R2 - Switch-off condition forces both outputs off
// R3 - Internal fault forces outputs off
// R4 - Controller goes safe if either output off
// R5 - Controller evaluates both channels separately
// R6 - Controller checks channel discrepancy time
// R7 - Reset button present enables restart interlock
// R8 - Interlock holds outputs off after powerup/interruption
// R9 - Press then release with clear field enables
// R10 - Machine restart needs separate start press
// R11 - One reset pushbutton per system
// R12 - Check contactor feedback before re-enabling
// R13 - Missing feedback level keeps outputs off
// R14 - Alignment aid active holds outputs off
// R15 - Momentary button press-release toggles alignment aid
// R16 - Maintained switch closed means alignment on
// R17 - Debounce, synchronise, act on release edge
// R18 - Outputs off until startup checks done
package soi_pkg;
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned DEBOUNCE_US     = 10_000;
	localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
	localparam int unsigned STARTUP_US      = 1_000;
	localparam int unsigned STARTUP_CYC     = (STARTUP_US * (CLK_HZ / 1_000_000));
	localparam logic [1:0]  BTN_IDLE        = 2'h0;

	// Output decision states, one-hot
	typedef enum logic [4:0] {
		SOI_ST_STARTUP = 5'h01,
		SOI_ST_OFF     = 5'h02,
		SOI_ST_WAIT    = 5'h04,
		SOI_ST_ON      = 5'h08,
		SOI_ST_LOCK    = 5'h10
	} soi_state_e;

	typedef struct packed {
		logic field_clear;
		logic int_fault;
		logic feedback_closed;
	} soi_sense_s;

	typedef struct packed {
		logic safety_switch_output_a;
		logic safety_switch_output_b;
	} soi_out_s;
endpackage

//--- rtl/soi_debounce.sv
// Synchroniser and debouncer for one pushbutton contact.
// Assumes raw input may bounce; emits the stable level and a release pulse.
`timescale 1ns/1ps
`default_nettype none
module soi_debounce #(
	parameter int unsigned CYCLES = soi_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Contact
	input  wire logic raw_in,
	output var  logic level,
	output var  logic release_pulse
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	// Elaboration check: a zero count would never validate a level
	if (CYCLES < 1) begin
		$error("CYCLES must be at least 1");
	end

	typedef struct packed {
		logic          s1;
		logic          s2;
		logic [CW-1:0] cnt;
		logic          stable;
		logic          rel;
	} soi_db_s;

	soi_db_s st_ff;
	soi_db_s nxt_st;

	always_comb begin
		nxt_st     = st_ff;
		nxt_st.s1  = raw_in;
		nxt_st.s2  = st_ff.s1;
		nxt_st.rel = 1'b0;
		if (st_ff.s2 == st_ff.stable) begin
			nxt_st.cnt = '0;
		end else if (st_ff.cnt == CW'(CYCLES - 1)) begin
			nxt_st.cnt    = '0;
			nxt_st.stable = st_ff.s2;
			nxt_st.rel    = st_ff.stable & ~st_ff.s2; // [R17]
		end else begin
			nxt_st.cnt = st_ff.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level         = st_ff.stable;
	assign release_pulse = st_ff.rel;

	release_only_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		release_pulse |-> ($past(level) && !level)) else $error("release pulse without falling level"); // [R17]
endmodule
`default_nettype wire

//--- rtl/soi_interlock.sv
// Output decision logic: drives two redundant safety switching outputs.
// Assumes field, fault and feedback inputs are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module soi_interlock #(
	parameter int unsigned DEBOUNCE_CYC = soi_pkg::DEBOUNCE_CYC,
	parameter int unsigned STARTUP_CYC  = soi_pkg::STARTUP_CYC
) (
	// Clock and reset
	input  wire logic           clk_sys,
	input  wire logic           rstn,
	// Field and device status
	input  wire soi_pkg::soi_sense_s sense,
	// Configuration straps
	input  wire logic           reset_button_present,
	input  wire logic           feedback_monitor_en,
	input  wire logic           alignment_is_switch,
	// Operator contacts
	input  wire logic           reset_button_raw,
	input  wire logic           alignment_switch_contact,
	// Outputs
	output var  soi_pkg::soi_out_s outs,
	output var  logic           alignment_aid_on,
	output var  logic           reset_required,
	output var  logic           contactor_fault
);
	localparam int unsigned SW = $clog2(STARTUP_CYC + 1);
	// Elaboration check: start-up must last at least one cycle
	if (STARTUP_CYC < 1) begin
		$error("STARTUP_CYC must be at least 1");
	end

	typedef struct packed {
		soi_pkg::soi_state_e state;
		logic [SW-1:0]       start_cnt;
		logic                align_tog;
		logic                cfg_restart;
		logic                cfg_edm;
		logic                cfg_sw;
		logic                out_a;
		logic                out_b;
		logic                edm_fail;
	} soi_main_s;

	soi_main_s st_ff;
	soi_main_s nxt_st;

	logic rst_release;
	logic al_level;
	logic al_release;
	logic align_active;
	logic hold_off;

	soi_debounce #(.CYCLES(DEBOUNCE_CYC)) u_db_reset (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.raw_in       (reset_button_raw),
		.level        (),
		.release_pulse(rst_release)
	);

	soi_debounce #(.CYCLES(DEBOUNCE_CYC)) u_db_align (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.raw_in       (alignment_switch_contact),
		.level        (al_level),
		.release_pulse(al_release)
	);

	// Maintained switch follows contact; momentary button toggles
	assign align_active = st_ff.cfg_sw ? al_level : st_ff.align_tog; // [R16] [R15]
	assign hold_off     = ~sense.field_clear | sense.int_fault | align_active; // [R2] [R3] [R14]

	always_comb begin
		nxt_st       = st_ff;
		nxt_st.out_a = 1'b0;
		nxt_st.out_b = 1'b0;
		if (!st_ff.cfg_sw && al_release) begin
			nxt_st.align_tog = ~st_ff.align_tog; // [R15]
		end
		case (st_ff.state)
			soi_pkg::SOI_ST_STARTUP: begin
				// Straps captured while start-up checks run
				nxt_st.cfg_restart = reset_button_present; // [R7]
				nxt_st.cfg_edm     = feedback_monitor_en;
				nxt_st.cfg_sw      = alignment_is_switch;
				if (st_ff.start_cnt == SW'(STARTUP_CYC - 1)) begin
					nxt_st.state = soi_pkg::SOI_ST_OFF; // [R18]
				end else begin
					nxt_st.start_cnt = st_ff.start_cnt + SW'(1);
				end
			end
			soi_pkg::SOI_ST_OFF: begin
				// Contactor must show closed-contact level once outputs are off
				if (st_ff.cfg_edm && !sense.feedback_closed) begin
					nxt_st.edm_fail = 1'b1; // [R12] [R13]
				end else if (st_ff.cfg_edm) begin
					nxt_st.edm_fail = 1'b0;
				end
				if (!hold_off && !(st_ff.cfg_edm && !sense.feedback_closed)) begin
					nxt_st.state = st_ff.cfg_restart ? soi_pkg::SOI_ST_LOCK : soi_pkg::SOI_ST_ON; // [R8]
				end
			end
			soi_pkg::SOI_ST_LOCK: begin
				if (hold_off || (st_ff.cfg_edm && !sense.feedback_closed)) begin
					nxt_st.state = soi_pkg::SOI_ST_OFF; // [R8]
				end else if (rst_release) begin
					nxt_st.state = soi_pkg::SOI_ST_ON; // [R9]
				end
			end
			soi_pkg::SOI_ST_ON: begin
				if (hold_off) begin
					nxt_st.state = soi_pkg::SOI_ST_OFF; // [R2]
				end else begin
					nxt_st.out_a = 1'b1; // [R1]
					nxt_st.out_b = 1'b1;
				end
			end
			default: begin
				nxt_st.state = soi_pkg::SOI_ST_OFF;
			end
		endcase
		// Immediate switch-off path independent of the state
		if (hold_off) begin
			nxt_st.out_a = 1'b0; // [R2] [R3]
			nxt_st.out_b = 1'b0;
		end
		if (st_ff.state != soi_pkg::SOI_ST_ON) begin
			nxt_st.out_a = 1'b0;
			nxt_st.out_b = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_ff       <= '0;
			st_ff.state <= soi_pkg::SOI_ST_STARTUP;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign outs.safety_switch_output_a = st_ff.out_a;
	assign outs.safety_switch_output_b = st_ff.out_b;
	assign alignment_aid_on            = align_active;
	assign reset_required              = (st_ff.state == soi_pkg::SOI_ST_LOCK);
	assign contactor_fault             = st_ff.edm_fail;

	// Assertions
	field_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
		!sense.field_clear |=> !outs.safety_switch_output_a && !outs.safety_switch_output_b)
		else $error("outputs on after interruption");
	fault_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
		sense.int_fault |=> !outs.safety_switch_output_a) else $error("output on during fault");
	align_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R14]
		align_active |=> !outs.safety_switch_output_b) else $error("output on during alignment");
	on_needs_state_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		$rose(outs.safety_switch_output_a) |-> $past(st_ff.state == soi_pkg::SOI_ST_ON, 1))
		else $error("output rose outside on state");
	lock_release_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
		(st_ff.state == soi_pkg::SOI_ST_LOCK) ##1 (st_ff.state == soi_pkg::SOI_ST_ON) |-> $past(rst_release))
		else $error("interlock left without reset release");
	lock_enter_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
		(st_ff.state == soi_pkg::SOI_ST_OFF) && st_ff.cfg_restart |=> st_ff.state != soi_pkg::SOI_ST_ON)
		else $error("interlock bypassed");
	no_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
		!st_ff.cfg_restart |-> st_ff.state != soi_pkg::SOI_ST_LOCK) else $error("interlock without button");
	edm_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R13]
		(st_ff.state == soi_pkg::SOI_ST_OFF) && st_ff.cfg_edm && !sense.feedback_closed
		|=> st_ff.state == soi_pkg::SOI_ST_OFF && contactor_fault) else $error("welded contactor ignored");
	startup_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R18]
		st_ff.state == soi_pkg::SOI_ST_STARTUP |-> !outs.safety_switch_output_a && !outs.safety_switch_output_b)
		else $error("output on during start-up");
	toggle_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R15]
		!st_ff.cfg_sw && al_release |=> st_ff.align_tog != $past(st_ff.align_tog))
		else $error("alignment did not toggle");
	// A debounced switch closure needs the raw contact closed over the whole window
	switch_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R16]
		st_ff.cfg_sw && $rose(al_level)
		|-> alignment_aid_on && $past(alignment_switch_contact, 3) && $past(alignment_switch_contact, 6))
		else $error("alignment not following switch");
	pair_equal_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		outs.safety_switch_output_a == outs.safety_switch_output_b) else $error("output channels differ");
	lock_off_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
		st_ff.state == soi_pkg::SOI_ST_LOCK |-> !outs.safety_switch_output_a && !outs.safety_switch_output_b)
		else $error("output on while interlock waits");
	edm_block_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R12]
		(st_ff.state == soi_pkg::SOI_ST_OFF) && st_ff.cfg_edm && !sense.feedback_closed
		|=> !outs.safety_switch_output_a && !outs.safety_switch_output_b)
		else $error("output on with open contactor feedback");
	on_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		(st_ff.state == soi_pkg::SOI_ST_ON) && !hold_off
		|=> outs.safety_switch_output_a && outs.safety_switch_output_b)
		else $error("outputs off with clear field");

	cov_on_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(outs.safety_switch_output_a));
	cov_lock_c: cover property (@(posedge clk_sys) disable iff (!rstn)
		(st_ff.state == soi_pkg::SOI_ST_LOCK) ##1 (st_ff.state == soi_pkg::SOI_ST_ON));
	cov_edm_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(contactor_fault));
	cov_align_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(alignment_aid_on));
endmodule
`default_nettype wire

//--- tb/soi_relay_model.sv
// Behavioural safety relay with two contactors behind the safety outputs.
// Assumes outputs change on clk_sys; each contactor follows its channel a cycle later.
`timescale 1ns/1ps
`default_nettype none
module soi_relay_model (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	// Device side
	input  wire soi_pkg::soi_out_s outs,
	output var  logic              feedback_closed,
	// Machine side
	input  wire logic              weld_fault,
	input  wire logic              start_btn,
	output var  logic              machine_run,
	output var  logic              mismatch_seen
);
	logic ka_ff;
	logic kb_ff;
	always_ff @(posedge clk_sys) begin
		ka_ff <= rstn & outs.safety_switch_output_a;
		kb_ff <= rstn & outs.safety_switch_output_b;
		if (!rstn || !(ka_ff & kb_ff)) begin
			machine_run <= 1'b0;
		end else if (start_btn) begin
			machine_run <= 1'b1;
		end
		// Zero discrepancy time tolerated
		mismatch_seen <= rstn & (mismatch_seen | (ka_ff ^ kb_ff));
	end
	// A welded contactor keeps its check contact open
	assign feedback_closed = !(ka_ff | kb_ff) && !weld_fault;
endmodule
`default_nettype wire

//--- tb/test_soi_interlock.sv
// Self-checking bench for the safety output interlock logic.
// Assumes short debounce and start-up counts; a reset button is fitted only in lock_run.
`timescale 1ns/1ps
`default_nettype none
module test_soi_interlock;
	logic                clk_sys, rstn, fld, flt, rbp, fbe, als, rbtn, acon, weld, start;
	logic                fb, aid, rreq, cfault, run, mism;
	soi_pkg::soi_sense_s sense;
	soi_pkg::soi_out_s   outs;
	int                  fail_count, total_checks;
	assign sense = {fld, flt, fb};
	soi_interlock #(.DEBOUNCE_CYC(4), .STARTUP_CYC(8)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
		.sense(sense), .reset_button_present(rbp), .feedback_monitor_en(fbe),
		.alignment_is_switch(als), .reset_button_raw(rbtn), .alignment_switch_contact(acon),
		.outs(outs), .alignment_aid_on(aid), .reset_required(rreq), .contactor_fault(cfault));
	soi_relay_model relay_u (.clk_sys(clk_sys), .rstn(rstn), .outs(outs), .feedback_closed(fb),
		.weld_fault(weld), .start_btn(start), .machine_run(run), .mismatch_seen(mism));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	// Waits up to n cycles for both channels to reach exp
	task automatic chk_outs(input string what, input logic exp, input int n);
		for (int i = 0; i < n && outs !== {exp, exp}; i++) step(1);
		total_checks++;
		if (outs !== {exp, exp}) begin
			fail_count++;
			$display("[ERR] %s expected %b seen %b", what, {exp, exp}, outs);
		end
	endtask
	task automatic press(input logic which);
		// The bench fits a single reset button on the one reset input
		if (which) begin
			rbtn = 1'b1;
		end else begin
			acon = 1'b1;
		end
		step(10);
		rbtn = 1'b0;
		acon = 1'b0;
		step(10);
	endtask
	task automatic restart(input logic p, input logic f, input logic s);
		rstn = 1'b0;
		rbp  = p;
		fbe  = f;
		als  = s;
		step(6);
		rstn = 1'b1;
		step(2);
		chk_outs("startup", 1'b0, 0);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic plain_run;
		restart(1'b0, 1'b0, 1'b0);
		chk_outs("clear", 1'b1, 20);
		chk("run_no_start", 1'b0, run);
		start = 1'b1;
		step(2);
		start = 1'b0;
		chk("run_start", 1'b1, run);
		fld = 1'b0;
		step(2);
		chk_outs("break", 1'b0, 0);
		// Relay contactors drop one cycle after the outputs, machine one after that
		step(1);
		chk("run_stop", 1'b0, run);
		fld = 1'b1;
		chk_outs("reclear", 1'b1, 20);
		flt = 1'b1;
		step(2);
		chk_outs("fault", 1'b0, 0);
		flt = 1'b0;
		chk_outs("unfault", 1'b1, 20);
		acon = 1'b1;
		step(2);
		acon = 1'b0;
		step(10);
		chk("glitch", 1'b0, aid);
		press(1'b0);
		chk("aid_toggle_on", 1'b1, aid);
		chk_outs("aid_hold", 1'b0, 0);
		press(1'b0);
		chk("aid_toggle_off", 1'b0, aid);
		chk_outs("aid_gone", 1'b1, 20);
	endtask
	task automatic switch_run;
		restart(1'b0, 1'b0, 1'b1);
		acon = 1'b1;
		step(12);
		chk("sw_closed", 1'b1, aid);
		chk_outs("sw_hold", 1'b0, 0);
		acon = 1'b0;
		step(12);
		chk("sw_open", 1'b0, aid);
		chk_outs("sw_free", 1'b1, 20);
	endtask
	task automatic lock_run;
		restart(1'b1, 1'b0, 1'b0);
		step(20);
		chk_outs("lock_power", 1'b0, 0);
		chk("lock_req", 1'b1, rreq);
		rbtn = 1'b1;
		step(10);
		chk_outs("lock_held", 1'b0, 0);
		rbtn = 1'b0;
		chk_outs("lock_release", 1'b1, 20);
		fld = 1'b0;
		step(2);
		chk_outs("lock_break", 1'b0, 0);
		fld = 1'b1;
		step(20);
		chk_outs("lock_again", 1'b0, 0);
		fld = 1'b0;
		press(1'b1);
		fld = 1'b1;
		step(20);
		chk_outs("lock_blocked", 1'b0, 0);
		press(1'b1);
		chk_outs("lock_ok", 1'b1, 20);
	endtask
	task automatic monitor_run;
		weld = 1'b1;
		restart(1'b0, 1'b1, 1'b0);
		step(20);
		chk_outs("fb_open", 1'b0, 0);
		chk("fb_fault", 1'b1, cfault);
		weld = 1'b0;
		chk_outs("fb_ok", 1'b1, 20);
		chk("fb_clear", 1'b0, cfault);
		fld = 1'b0;
		weld = 1'b1;
		step(4);
		fld = 1'b1;
		step(20);
		chk_outs("fb_weld", 1'b0, 0);
		chk("fb_weld_fault", 1'b1, cfault);
		weld = 1'b0;
	endtask
	initial begin
		#(4000 * 50);
		fail_count++;
		give_verdict();
	end
	initial begin
		{rstn, flt, rbp, fbe, als, rbtn, acon, weld, start} = '0;
		fld = 1'b1;
		fail_count = 0;
		total_checks = 0;
		step(1);
		plain_run();
		switch_run();
		lock_run();
		monitor_run();
		chk("discrepancy", 1'b0, mism);
		give_verdict();
	end
endmodule
`default_nettype wire
